// ===== pkg/hub_cfg_pkg.sv
// shared constants and types for the memory hub configuration block
// assumes one core clock and a synchronous active-low reset everywhere
`default_nettype none

package hub_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register placement and reset pattern
   localparam int CFG_W = 8;
   localparam logic [7:0] CFG_OFFSET = 8'h50;
   // 010s0s00 with the strap bits at their undriven levels (pull-up, 100)
   localparam logic [7:0] CFG_RESET = 8'h50;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
   localparam logic RSV_ZERO = 1'b0;
   localparam logic [1:0] RSV2_ZERO = 2'h0;

   // frequency select encodings
   localparam logic FREQ_100 = 1'b0;
   localparam logic FREQ_133 = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // timing counts, in core clocks or packets
   localparam int CAP_W = 3;
   localparam int WIN_W = 5;
   localparam int STALL_W = 5;
   localparam int SETTLE_W = 2;
   localparam logic [CAP_W-1:0] H2G_CAP = 3'h6;
   localparam logic [CAP_W-1:0] CAP_ONE = 3'h1;
   localparam logic [WIN_W-1:0] WIN_CLOCKS = 5'h18;
   localparam logic [WIN_W-1:0] WIN_ONE = 5'h01;
   localparam logic [STALL_W-1:0] STALL_CLOCKS = 5'h1f;
   localparam logic [STALL_W-1:0] STALL_ONE = 5'h01;
   // three synchroniser stages must fill before a strap is trusted
   localparam logic [SETTLE_W-1:0] STRAP_SETTLE = 2'h3;
   localparam logic [SETTLE_W-1:0] SETTLE_ONE = 2'h1;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic grant_window_enable;
      logic processor_latency_timer;
      logic rsvd_5;
      logic local_memory_freq_select;
      logic page_closing_policy;
      logic system_memory_freq_select;
      logic [1:0] rsvd_1_0;
   } cfg_t;

   typedef struct packed {
      logic h2g;
      logic other;
      logic host;
      logic lpg;
   } arb_req_t;

   typedef struct packed {
      logic page_miss;
      logic row_change;
      logic any_page_open;
      logic refresh_start;
   } dram_evt_t;

   typedef enum logic {OWN_HOST = 1'b0, OWN_GFX = 1'b1} owner_t;

   typedef enum logic [1:0] {
      ST_SETTLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b11
   } strap_st_t;

endpackage

`default_nettype wire

// ===== design/strap_capture.sv
// strap capture: synchronises strap pins and loads them once after reset
// assumes the pins hold steady for some cycles after reset release
`default_nettype none

module strap_capture #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // strap pins
   input wire logic [WIDTH-1:0] pin,
   // captured value and load pulse
   output logic [WIDTH-1:0] value_r,
   output logic load_r
);

   logic [WIDTH-1:0] s1_r, s2_r, s3_r;
   logic [WIDTH-1:0] value_nxt;
   logic load_nxt;
   logic [hub_cfg_pkg::SETTLE_W-1:0] cnt_r, cnt_nxt;
   hub_cfg_pkg::strap_st_t st_r, st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // settle, then take the value once the last two stages agree
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      value_nxt = value_r;
      load_nxt = 1'b0;
      case (st_r)
         hub_cfg_pkg::ST_SETTLE: begin
            if (cnt_r == hub_cfg_pkg::STRAP_SETTLE) begin
               st_nxt = hub_cfg_pkg::ST_WAIT;
            end else begin
               cnt_nxt = cnt_r + hub_cfg_pkg::SETTLE_ONE;
            end
         end
         hub_cfg_pkg::ST_WAIT: begin
            if (s2_r == s3_r) begin
               value_nxt = s3_r;
               load_nxt = 1'b1;
               st_nxt = hub_cfg_pkg::ST_DONE;
            end
         end
         hub_cfg_pkg::ST_DONE: begin
            st_nxt = hub_cfg_pkg::ST_DONE;
         end
         default: begin
            st_nxt = hub_cfg_pkg::ST_SETTLE;
         end
      endcase
   end

   // s1 feeds only s2; a metastable first stage must not reach logic
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         st_r <= hub_cfg_pkg::ST_SETTLE;
         cnt_r <= '0;
         value_r <= '0;
         load_r <= 1'b0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         value_r <= value_nxt;
         load_r <= load_nxt;
      end
   end

   a_load_once: assert property (@(posedge clk) disable iff (!nrst)
      load_r |=> (!load_r)[*8])
      else $error("strap loaded twice");

endmodule

`default_nettype wire

// ===== design/defer_timer.sv
// defer timer: decides when a stalled deferrable processor cycle is deferred
// assumes stall_pending and address_strobe come from core-clock logic
`default_nettype none

module defer_timer #(
   parameter logic [hub_cfg_pkg::STALL_W-1:0] STALL = hub_cfg_pkg::STALL_CLOCKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control and events
   input wire logic latency_timer,
   input wire logic stall_pending,
   input wire logic address_strobe,
   // defer pulse
   output logic defer_r
);

   logic [hub_cfg_pkg::STALL_W-1:0] cnt_r, cnt_nxt;
   logic defer_nxt;

   ////////////////////////////////////////////////////////////////////////
   // stall counter saturates, so a long stall never wraps back to zero
   always_comb begin
      cnt_nxt = cnt_r;
      defer_nxt = 1'b0;
      if (!stall_pending) begin
         cnt_nxt = '0;
      end else begin
         if (cnt_r != STALL) begin
            cnt_nxt = cnt_r + hub_cfg_pkg::STALL_ONE;
         end
         // defer on next strobe; with the timer on, only after the full stall
         if (address_strobe && (!latency_timer || cnt_r == STALL)) begin
            defer_nxt = 1'b1;
            cnt_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_r <= '0;
         defer_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         defer_r <= defer_nxt;
      end
   end

   a_defer_now: assert property (@(posedge clk) disable iff (!nrst)
      stall_pending && address_strobe && !latency_timer |=> defer_r)
      else $error("no immediate defer with timer off");

   a_defer_hold: assert property (@(posedge clk) disable iff (!nrst)
      latency_timer && cnt_r != STALL |=> !defer_r)
      else $error("defer before stall elapsed");

endmodule

`default_nettype wire

// ===== design/memory_arbiter_config_register.sv
// memory hub configuration register with the arbiter, defer and page logic
// that it steers; assumes a plain one-cycle register port on the core clock
// and that gfx_mode mirrors the graphics-select bit of aperture control
`default_nettype none

module memory_arbiter_config_register #(
   parameter logic [hub_cfg_pkg::CAP_W-1:0] CAP = hub_cfg_pkg::H2G_CAP,
   parameter logic [hub_cfg_pkg::WIN_W-1:0] WIN = hub_cfg_pkg::WIN_CLOCKS,
   parameter logic [hub_cfg_pkg::STALL_W-1:0] STALL = hub_cfg_pkg::STALL_CLOCKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   output logic [7:0] cfg_rdata,
   // mode and straps
   input wire logic gfx_mode,
   input wire logic local_freq_strap,
   input wire logic system_freq_strap_pin,
   // arbiter requests and grants
   input wire hub_cfg_pkg::arb_req_t req,
   output logic s1_h2g_gnt,
   output logic s1_other_gnt,
   output logic host_gnt,
   output logic lpg_gnt,
   // processor deferral
   input wire logic stall_pending,
   input wire logic address_strobe,
   output logic defer_cycle,
   // dram page control
   input wire hub_cfg_pkg::dram_evt_t dram_evt,
   output logic precharge_bank,
   output logic precharge_all,
   // frequency selects
   output logic lm_freq_select,
   output logic sm_freq_select
);

   hub_cfg_pkg::cfg_t cfg_r, cfg_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [1:0] strap_val;
   logic strap_load;
   logic s1_h2g_r, s1_h2g_nxt, s1_other_r, s1_other_nxt;
   logic [hub_cfg_pkg::CAP_W-1:0] s1_cnt_r, s1_cnt_nxt;
   hub_cfg_pkg::owner_t owner_r, owner_nxt;
   logic [hub_cfg_pkg::WIN_W-1:0] win_r, win_nxt;
   logic host_r, host_nxt, lpg_r, lpg_nxt;
   logic bank_r, bank_nxt, all_r, all_nxt;
   logic gwe;

   // register address decode, shared by reads and writes
   function automatic logic cfg_hit(input logic [7:0] addr);
      cfg_hit = (addr == hub_cfg_pkg::CFG_OFFSET);
   endfunction

   assign gwe = cfg_r.grant_window_enable;

   ////////////////////////////////////////////////////////////////////////
   // strap capture, system pin in bit 1 and local strap in bit 0
   strap_capture #(
      .WIDTH(2)
   ) u_strap (
      .clk(clk),
      .nrst(nrst),
      .pin({system_freq_strap_pin, local_freq_strap}),
      .value_r(strap_val),
      .load_r(strap_load)
   );

   ////////////////////////////////////////////////////////////////////////
   // configuration register and read port
   always_comb begin
      cfg_nxt = cfg_r;
      rdata_nxt = hub_cfg_pkg::RDATA_IDLE;
      // write at the one decoded offset
      if (cfg_wr && cfg_hit(cfg_addr)) begin
         cfg_nxt = hub_cfg_pkg::cfg_t'(cfg_wdata);
      end
      // strap wins over a write in the single load cycle
      if (strap_load) begin
         cfg_nxt.local_memory_freq_select = strap_val[0];
         // system pin level becomes the default
         cfg_nxt.system_memory_freq_select = strap_val[1];
      end
      // hardwired to 100 while internal graphics is selected
      if (gfx_mode) begin
         cfg_nxt.system_memory_freq_select = hub_cfg_pkg::FREQ_100;
      end
      cfg_nxt.rsvd_5 = hub_cfg_pkg::RSV_ZERO;
      cfg_nxt.rsvd_1_0 = hub_cfg_pkg::RSV2_ZERO;
      // data only in the cycle after the strobe, zero elsewhere
      if (cfg_rd && cfg_hit(cfg_addr)) begin
         rdata_nxt = cfg_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_r <= hub_cfg_pkg::cfg_t'(hub_cfg_pkg::CFG_RESET);
         rdata_r <= hub_cfg_pkg::RDATA_IDLE;
      end else begin
         cfg_r <= cfg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage one pre-arbiter, counts back-to-back host-to-graphics grants
   always_comb begin
      s1_h2g_nxt = 1'b0;
      s1_other_nxt = 1'b0;
      s1_cnt_nxt = '0;
      // after the cap, other requesters get one turn
      if (gwe && s1_cnt_r == CAP && req.other) begin
         s1_other_nxt = 1'b1;
      end else if (req.h2g) begin
         // fixed priority keeps the host side ahead
         s1_h2g_nxt = 1'b1;
         if (gwe && s1_cnt_r != CAP) begin
            s1_cnt_nxt = s1_cnt_r + hub_cfg_pkg::CAP_ONE;
         end else if (gwe) begin
            s1_cnt_nxt = s1_cnt_r;
         end
      end else if (req.other) begin
         s1_other_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_h2g_r <= 1'b0;
         s1_other_r <= 1'b0;
         s1_cnt_r <= '0;
      end else begin
         s1_h2g_r <= s1_h2g_nxt;
         s1_other_r <= s1_other_nxt;
         s1_cnt_r <= s1_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage two arbiter; window counts clocks granted to the owner, and an
   // idle owner is not waited for, trading strict slots for utilisation
   always_comb begin
      owner_nxt = owner_r;
      win_nxt = win_r;
      host_nxt = 1'b0;
      lpg_nxt = 1'b0;
      if (!gwe) begin
         owner_nxt = hub_cfg_pkg::OWN_HOST;
         win_nxt = '0;
         if (req.host) begin
            host_nxt = 1'b1;
         end else if (req.lpg) begin
            lpg_nxt = 1'b1;
         end
      end else begin
         case (owner_r)
            hub_cfg_pkg::OWN_HOST: begin
               if (req.host && win_r < WIN) begin
                  host_nxt = 1'b1;
                  win_nxt = win_r + hub_cfg_pkg::WIN_ONE;
               end else if (req.lpg) begin
                  // hand over at expiry or when host is idle
                  lpg_nxt = 1'b1;
                  owner_nxt = hub_cfg_pkg::OWN_GFX;
                  win_nxt = hub_cfg_pkg::WIN_ONE;
               end else if (req.host) begin
                  host_nxt = 1'b1;
                  win_nxt = hub_cfg_pkg::WIN_ONE;
               end
            end
            hub_cfg_pkg::OWN_GFX: begin
               if (req.lpg && win_r < WIN) begin
                  lpg_nxt = 1'b1;
                  win_nxt = win_r + hub_cfg_pkg::WIN_ONE;
               end else if (req.host) begin
                  // idle graphics window goes back to host
                  host_nxt = 1'b1;
                  owner_nxt = hub_cfg_pkg::OWN_HOST;
                  win_nxt = hub_cfg_pkg::WIN_ONE;
               end else if (req.lpg) begin
                  lpg_nxt = 1'b1;
                  win_nxt = hub_cfg_pkg::WIN_ONE;
               end
            end
            default: begin
               owner_nxt = hub_cfg_pkg::OWN_HOST;
               win_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         owner_r <= hub_cfg_pkg::OWN_HOST;
         win_r <= '0;
         host_r <= 1'b0;
         lpg_r <= 1'b0;
      end else begin
         owner_r <= owner_nxt;
         win_r <= win_nxt;
         host_r <= host_nxt;
         lpg_r <= lpg_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // deferral of stalled processor cycles
   defer_timer #(
      .STALL(STALL)
   ) u_defer (
      .clk(clk),
      .nrst(nrst),
      .latency_timer(cfg_r.processor_latency_timer),
      .stall_pending(stall_pending),
      .address_strobe(address_strobe),
      .defer_r(defer_cycle)
   );

   ////////////////////////////////////////////////////////////////////////
   // page closing commands; precharge-all covers the bank, so it wins
   always_comb begin
      // row change with open pages and refresh lead-in
      all_nxt = dram_evt.refresh_start || (dram_evt.row_change && dram_evt.any_page_open);
      all_nxt = all_nxt || (dram_evt.page_miss && cfg_r.page_closing_policy);
      bank_nxt = dram_evt.page_miss && !cfg_r.page_closing_policy && !all_nxt;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         bank_r <= 1'b0;
         all_r <= 1'b0;
      end else begin
         bank_r <= bank_nxt;
         all_r <= all_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, each straight from a flop
   assign cfg_rdata = rdata_r;
   assign s1_h2g_gnt = s1_h2g_r;
   assign s1_other_gnt = s1_other_r;
   assign host_gnt = host_r;
   assign lpg_gnt = lpg_r;
   assign precharge_bank = bank_r;
   assign precharge_all = all_r;
   assign lm_freq_select = cfg_r.local_memory_freq_select;
   assign sm_freq_select = cfg_r.system_memory_freq_select;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence seq_cfg_write;
      cfg_wr && cfg_hit(cfg_addr) && !strap_load && !gfx_mode;
   endsequence

   sequence seq_cfg_read;
      cfg_rd && cfg_hit(cfg_addr);
   endsequence

   a_write_then_read: assert property (seq_cfg_write ##1 seq_cfg_read
      |=> cfg_rdata == {$past(cfg_wdata, 2) & 8'hdc})
      else $error("write not read back");

   a_reserved_zero: assert property (cfg_rdata[5] == 1'b0
      && cfg_rdata[1:0] == 2'h0)
      else $error("reserved bits not zero");

   a_fixed_host: assert property (!gwe && req.host |=> host_gnt && !lpg_gnt)
      else $error("host not favoured in fixed mode");

   a_h2g_cap: assert property (gwe && s1_cnt_r == CAP && req.other
      |=> s1_other_gnt && !s1_h2g_gnt)
      else $error("h2g cap not enforced");

   a_host_window: assert property (gwe && owner_r == hub_cfg_pkg::OWN_HOST
      && win_r == WIN && req.lpg |=> lpg_gnt && !host_gnt)
      else $error("host window overrun");

   a_gfx_window: assert property (gwe && owner_r == hub_cfg_pkg::OWN_GFX
      && win_r < WIN && req.lpg |=> lpg_gnt)
      else $error("graphics window cut short");

   a_idle_handover: assert property (gwe && !req.host && req.lpg
      |=> lpg_gnt ##1 owner_r == hub_cfg_pkg::OWN_GFX || !gwe || !lpg_gnt)
      else $error("idle window not handed over");

   a_system_memory_freq_select_gfx: assert property (gfx_mode |=> !cfg_r.system_memory_freq_select)
      else $error("system freq not forced in graphics mode");

   a_strap_take: assert property (strap_load && !gfx_mode
      |=> sm_freq_select == $past(strap_val[1]) && lm_freq_select == $past(strap_val[0]))
      else $error("strap not loaded");

   a_prech_all: assert property (dram_evt.refresh_start
      || (dram_evt.page_miss && cfg_r.page_closing_policy) |=> precharge_all && !precharge_bank)
      else $error("precharge all missing");

   a_prech_bank: assert property (dram_evt.page_miss && !cfg_r.page_closing_policy
      && !dram_evt.refresh_start && !dram_evt.row_change |=> precharge_bank && !precharge_all)
      else $error("bank precharge missing");

endmodule

`default_nettype wire

// ===== verification/memory_arbiter_config_register_test.sv
// self-checking bench for the memory hub configuration register block
// assumes the hub_cfg_pkg package is compiled first; bench drives every port
`default_nettype none

module memory_arbiter_config_register_test;
   timeunit 1ns;
   timeprecision 1ps;

   // shortened counts keep the arbiter and stall runs brief
   localparam int CAP_N = 3;
   localparam int WIN_N = 4;
   localparam int STALL_N = 5;

   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [7:0] cfg_wdata = 8'h00;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [7:0] cfg_rdata;
   logic gfx_mode = 1'b0;
   logic local_freq_strap = 1'b0;
   logic system_freq_strap_pin = 1'b1;
   hub_cfg_pkg::arb_req_t req = '0;
   logic s1_h2g_gnt, s1_other_gnt, host_gnt, lpg_gnt;
   logic stall_pending = 1'b0;
   logic address_strobe = 1'b0;
   logic defer_cycle;
   hub_cfg_pkg::dram_evt_t dram_evt = '0;
   logic precharge_bank, precharge_all, lm_freq_select, sm_freq_select;
   int fail_count = 0;
   int checks = 0;
   logic [7:0] model;

   memory_arbiter_config_register #(.CAP(3'h3), .WIN(5'h04), .STALL(5'h05))
   memory_arbiter_config_register_inst (
      .clk(clk), .nrst(nrst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .gfx_mode(gfx_mode),
      .local_freq_strap(local_freq_strap), .system_freq_strap_pin(system_freq_strap_pin),
      .req(req), .s1_h2g_gnt(s1_h2g_gnt), .s1_other_gnt(s1_other_gnt),
      .host_gnt(host_gnt), .lpg_gnt(lpg_gnt), .stall_pending(stall_pending),
      .address_strobe(address_strobe), .defer_cycle(defer_cycle), .dram_evt(dram_evt),
      .precharge_bank(precharge_bank), .precharge_all(precharge_all),
      .lm_freq_select(lm_freq_select), .sm_freq_select(sm_freq_select));

   // 125 MHz core clock
   always #4 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // expectation functions

   // reserved bits drop, system frequency is held low under graphics mode
   function automatic logic [7:0] next_reg(input logic [7:0] d, input logic g);
      next_reg = {d[7:6], 1'b0, d[4:3], d[2] & ~g, 2'h0};
   endfunction

   // precharge-all wins over the single-bank precharge when both apply
   function automatic logic [1:0] exp_page(input logic [3:0] e, input logic pol);
      logic all;
      all = e[0] | (e[2] & e[1]) | (e[3] & pol);
      exp_page = {e[3] & ~pol & ~all, all};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // shared tasks

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // a wait whose bound ran out ends the run
   task automatic need(input bit ok, input string nm);
      if (!ok) begin
         chk(nm, 8'h01, 8'h00);
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe; called just after an edge,
   // so a read may follow a write with no idle cycle between the strobes
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      cfg_addr <= a;
      cfg_rd <= 1'b1;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      chk(nm, exp, cfg_rdata);
   endtask

   // counts grants of the first stream until the second stream is granted
   task automatic run_arb(input int sel, input int n, output int na, output bit sb);
      logic a, b;
      na = 0;
      sb = 1'b0;
      for (int i = 0; i < n && !sb; i++) begin
         @(posedge clk);
         #1;
         case (sel)
            0: {a, b} = {s1_h2g_gnt, s1_other_gnt};
            1: {a, b} = {host_gnt, lpg_gnt};
            default: {a, b} = {lpg_gnt, host_gnt};
         endcase
         if (b === 1'b1) sb = 1'b1;
         else if (a === 1'b1) na++;
      end
   endtask

   // stall held from c0, strobe sampled at edge ck+1
   task automatic defer_try(input int k, input logic e);
      @(posedge clk);
      stall_pending <= 1'b1;
      repeat (k) @(posedge clk);
      address_strobe <= 1'b1;
      @(posedge clk);
      address_strobe <= 1'b0;
      stall_pending <= 1'b0;
      #1;
      chk("defer", {7'h0, e}, {7'h0, defer_cycle});
      repeat (2) @(posedge clk);
   endtask

   task automatic strap_reset(input logic lm, input logic sm, input logic [7:0] exp);
      @(posedge clk);
      nrst <= 1'b0;
      local_freq_strap <= lm;
      system_freq_strap_pin <= sm;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
      rd(8'h50, exp, "reset value");
      chk("freq pins", {6'h0, exp[4], exp[2]}, {6'h0, lm_freq_select, sm_freq_select});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int na;
      bit sb;
      logic g;
      logic [7:0] a, d;
      void'($urandom(18939));
      strap_reset(1'b0, 1'b1, 8'h44);
      rd(8'h51, 8'h00, "unmapped read");
      wr(8'h50, 8'hff);
      rd(8'h50, 8'hdc, "reserved bits");
      model = 8'hdc;
      // random traffic, some of it off the register or under graphics mode
      for (int i = 0; i < 16; i++) begin
         g = ($urandom % 4) == 0;
         a = (($urandom % 3) == 0) ? 8'($urandom) : 8'h50;
         d = 8'($urandom);
         if (g) d[4] = model[4]; // local freq left alone under graphics
         @(posedge clk);
         gfx_mode <= g;
         if (g) model[2] = 1'b0;
         wr(a, d);
         if (a == 8'h50) model = next_reg(d, g);
         rd(8'h50, model, "cfg random");
         chk("freq ports", {6'h0, model[4], model[2]}, {6'h0, lm_freq_select, sm_freq_select});
      end
      @(posedge clk);
      gfx_mode <= 1'b0;
      $display("test register done");
      // stage two windows then idle hand-over
      wr(8'h50, 8'hc0);
      req <= hub_cfg_pkg::arb_req_t'(4'h3);
      run_arb(1, 3 * WIN_N, na, sb);
      need(sb, "lpg window");
      chk("host window", 8'(WIN_N), 8'(na));
      req <= hub_cfg_pkg::arb_req_t'(4'h2);
      run_arb(2, 3, na, sb);
      need(sb, "idle hand-over");
      // host goes idle inside its own window: graphics is granted at once
      req <= hub_cfg_pkg::arb_req_t'(4'h1);
      run_arb(1, 3, na, sb);
      chk("host idle hand-over", 8'h00, 8'(na));
      need(sb, "host idle hand-over");
      wr(8'h50, 8'h40);
      req <= hub_cfg_pkg::arb_req_t'(4'h3);
      run_arb(1, 3 * WIN_N, na, sb);
      chk("fixed stage2", 8'h00, {7'h0, sb});
      // stage one packet cap
      req <= hub_cfg_pkg::arb_req_t'(4'h0);
      wr(8'h50, 8'hc0);
      req <= hub_cfg_pkg::arb_req_t'(4'hc);
      run_arb(0, 4 * CAP_N, na, sb);
      need(sb, "other grant");
      chk("h2g run", 8'(CAP_N), 8'(na));
      wr(8'h50, 8'h40); // back to fixed priority
      run_arb(0, 4 * CAP_N, na, sb);
      chk("fixed stage1", 8'h00, {7'h0, sb});
      req <= hub_cfg_pkg::arb_req_t'(4'h0);
      $display("test arbiter done");
      // deferral on the next strobe or after the full stall
      wr(8'h50, 8'h00);
      defer_try(1, 1'b1);
      wr(8'h50, 8'h40);
      defer_try(STALL_N, 1'b1);
      defer_try(STALL_N - 1, 1'b0);
      $display("test defer done");
      // every event mix under both page policies
      for (int p = 0; p < 2; p++) begin
         wr(8'h50, p[0] ? 8'h48 : 8'h40);
         for (int e = 0; e < 16; e++) begin
            @(posedge clk);
            dram_evt <= hub_cfg_pkg::dram_evt_t'(e[3:0]);
            @(posedge clk);
            dram_evt <= '0;
            #1;
            chk("precharge", {6'h0, exp_page(e[3:0], p[0])}, {6'h0, precharge_bank, precharge_all});
         end
      end
      $display("test page done");
      strap_reset(1'b1, 1'b0, 8'h50);
      $display("test second reset done");
      report_and_stop();
   end
endmodule

`default_nettype wire
